// ### src/slwu_pkg.sv
// shared constants for the stream link write unit
`default_nettype none
package slwu_pkg;
  // instruction word, bit 31 is the most significant bit
  localparam logic [5:0] OPC_STATIC  = 6'h1b;
  localparam logic [5:0] OPC_DYNAMIC = 6'h13;
  localparam int OPC_HI  = 31;
  localparam int OPC_LO  = 26;
  // static form flag positions
  localparam int ST_PUT  = 15;
  localparam int ST_NB   = 14;
  localparam int ST_CTL  = 13;
  localparam int ST_TST  = 12;
  localparam int ST_ATM  = 11;
  localparam int ST_LNK_HI = 3;
  localparam int ST_LNK_LO = 0;
  // dynamic form flag positions
  localparam int DY_PUT  = 10;
  localparam int DY_NB   = 9;
  localparam int DY_CTL  = 8;
  localparam int DY_TST  = 7;
  localparam int DY_ATM  = 6;

  localparam int MAX_LINKS = 16;
  localparam logic [4:0] EC_PRIV = 5'h07;

  // register map, byte addresses
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK   = 4'h4;
  localparam logic [3:0] OFS_STATE  = 4'h8;
  localparam logic [3:0] OFS_STALLS = 4'hc;
  localparam int EVT_W = 5;
  localparam logic [EVT_W-1:0] MASK_RST = 5'h00;
  // status event bits
  localparam int EV_WRITE   = 0;
  localparam int EV_NOSPACE = 1;
  localparam int EV_PRIV    = 2;
  localparam int EV_ABORT   = 3;
  localparam int EV_ILLEGAL = 4;
  localparam logic [15:0] STALL_MAX = 16'hffff;
endpackage
`default_nettype wire

// ### src/slwu_op_if.sv
// decoded put operation passed from decoder to execution logic
`timescale 1ns/1ns
`default_nettype none
interface slwu_op_if;
  logic       legal;
  logic       dynamic;
  logic       nonblock;
  logic       control;
  logic       test;
  logic       atomic;
  logic [3:0] link;
  modport producer (output legal, dynamic, nonblock, control, test,
                    atomic, link);
  modport consumer (input legal, dynamic, nonblock, control, test,
                    atomic, link);
endinterface
`default_nettype wire

// ### src/slwu_decode.sv
// instruction decoder for static and dynamic put forms
`timescale 1ns/1ns
`default_nettype none
module slwu_decode #(
  parameter int LINKS = 16,
  parameter int EXT   = 1
) (
  input  wire logic [31:0] instr,
  input  wire logic [3:0]  rb_low,
  slwu_op_if.producer      op
);
  wire is_static  = instr[slwu_pkg::OPC_HI:slwu_pkg::OPC_LO]
                    == slwu_pkg::OPC_STATIC && instr[slwu_pkg::ST_PUT];
  wire is_dynamic = instr[slwu_pkg::OPC_HI:slwu_pkg::OPC_LO]
                    == slwu_pkg::OPC_DYNAMIC && instr[slwu_pkg::DY_PUT];
  wire [3:0] raw_link = is_dynamic ? rb_low                   // see RL11
      : instr[slwu_pkg::ST_LNK_HI:slwu_pkg::ST_LNK_LO];      // see RL1
  wire ext_bits = is_dynamic
      ? (instr[slwu_pkg::DY_TST] | instr[slwu_pkg::DY_ATM])
      : (instr[slwu_pkg::ST_TST] | instr[slwu_pkg::ST_ATM]);
  wire ext_on = (EXT == 1);

  // see RL13
  assign op.legal    = LINKS > 0 && ((is_static && (!ext_bits || ext_on))
                       || (is_dynamic && ext_on));
  assign op.dynamic  = is_dynamic;
  assign op.nonblock = is_dynamic ? instr[slwu_pkg::DY_NB]
                                  : instr[slwu_pkg::ST_NB];
  assign op.control  = is_dynamic ? instr[slwu_pkg::DY_CTL]
                                  : instr[slwu_pkg::ST_CTL];
  assign op.test     = is_dynamic ? instr[slwu_pkg::DY_TST]
                                  : instr[slwu_pkg::ST_TST];
  assign op.atomic   = is_dynamic ? instr[slwu_pkg::DY_ATM]
                                  : instr[slwu_pkg::ST_ATM];
  // out of range index falls back to link 0
  assign op.link     = ({28'h0000000, raw_link} >= LINKS) ? 4'h0
                       : raw_link;                  // see RL2, see RL11
endmodule
`default_nettype wire

// ### src/slwu_regs.sv
// status, mask and read-only registers with level interrupt
`timescale 1ns/1ns
`default_nettype none
module slwu_regs (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic [3:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [31:0]                       reg_rdata,
  input  wire logic [slwu_pkg::EVT_W-1:0]   events,
  input  wire logic [31:0]                  state_word,
  input  wire logic [15:0]                  stall_count,
  output logic                              irq
);
  logic [slwu_pkg::EVT_W-1:0] status_reg;
  logic [slwu_pkg::EVT_W-1:0] status_next;
  logic [slwu_pkg::EVT_W-1:0] mask_reg;
  logic [31:0]                rd_word;

  wire sel_status = reg_addr == slwu_pkg::OFS_STATUS;
  wire sel_mask   = reg_addr == slwu_pkg::OFS_MASK;
  wire sel_state  = reg_addr == slwu_pkg::OFS_STATE;
  wire sel_stalls = reg_addr == slwu_pkg::OFS_STALLS;

  // read clears, but an event in the same cycle survives
  assign status_next = ((reg_rd && sel_status) ? '0 : status_reg) | events;
  assign rd_word = sel_status ? {27'h0000000, status_reg}
                 : sel_mask   ? {27'h0000000, mask_reg}
                 : sel_state  ? state_word
                 : sel_stalls ? {16'h0000, stall_count}
                 : 32'h00000000;
  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= '0;
      mask_reg   <= slwu_pkg::MASK_RST;
      reg_rdata  <= 32'h00000000;
    end else begin
      status_reg <= status_next;
      if (reg_wr && sel_mask)
        mask_reg <= reg_wdata[slwu_pkg::EVT_W-1:0];
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### src/slwu_top.sv
// stream link write unit: executes put instructions onto output links
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RL1 - write source word to link from field
// RL2 - out of range link index uses 0
// RL3 - blocking form stalls until link has space
// RL4 - non-blocking never stalls, carry shows no-space
// RL5 - control bit follows instruction control flag
// RL6 - test form checks space, never strobes write
// RL7 - atomic form holds off interrupts afterwards
// RL8 - user mode access faults when memory managed
// RL9 - one cycle, two with area setting 1
// RL10 - static stall serves interrupts if extended, non-atomic
// RL11 - dynamic form takes link from rb low bits
// RL12 - dynamic stall serves interrupts unless atomic
// RL13 - forms exist only under link, extension params
// RL14 - consumer shows space, takes data on strobe
module slwu_top #(
  parameter int LINKS        = 16,
  parameter int EXT          = 1,
  parameter int MMU_LEVEL    = 0,
  parameter int USER_ACCESS  = 0,
  parameter int AREA         = 0
) (
  input  wire logic              clk,
  input  wire logic              srst,
  // issue side from the pipeline
  input  wire logic              issue_valid,
  output logic                   issue_ready,
  input  wire logic [31:0]       instr,
  input  wire logic [31:0]       src_a,
  input  wire logic [31:0]       src_b,
  input  wire logic              user_mode_flag,
  input  wire logic              irq_pending,
  input  wire logic              retire_pulse,
  // completion side
  output logic                   op_done,
  output logic                   op_stall,
  output logic                   op_abort,
  output logic                   carry_wr,
  output logic                   carry_flag,
  output logic                   priv_fault,
  output logic                   illegal_op,
  output logic [4:0]             exception_cause_field,
  output logic                   irq_block,
  // outgoing stream links
  output logic [31:0]            link_data,
  output logic                   link_ctrl,
  output logic [LINKS-1:0]       link_wr,
  input  wire logic [LINKS-1:0]  link_space,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   irq
);
  // values the logic cannot serve stop elaboration
  if (LINKS < 1 || LINKS > slwu_pkg::MAX_LINKS) begin : g_chk_links
    $error("link count must lie in 1..16");
  end
  if (EXT < 0 || EXT > 1) begin : g_chk_ext
    $error("extended stream ops must be 0 or 1");
  end
  if (USER_ACCESS < 0 || USER_ACCESS > 1) begin : g_chk_user
    $error("user stream access must be 0 or 1");
  end
  if (AREA < 0 || AREA > 2) begin : g_chk_area
    $error("area tuning must be 0, 1 or 2");
  end
  if (MMU_LEVEL < 0) begin : g_chk_mmu
    $error("memory management level must not be negative");
  end

  typedef enum logic [1:0] {
    SLWU_IDLE,
    SLWU_SETTLE,
    SLWU_EXEC
  } slwu_state_t;

  slwu_state_t state_reg;
  slwu_state_t state_next;

  // operation latched at issue
  logic [31:0] data_reg;
  logic        ctrl_reg;
  logic        nb_reg;
  logic        test_reg;
  logic        atom_reg;
  logic        dyn_reg;
  logic        legal_reg;
  logic        priv_reg;
  logic [3:0]  link_reg;

  logic        inhibit_reg;
  logic        inhibit_next;
  logic [4:0]  cause_reg;
  logic        carry_last_reg;
  logic [15:0] stall_cnt_reg;
  logic [15:0] stall_cnt_next;

  slwu_op_if op_bus ();

  slwu_decode #(
    .LINKS (LINKS),
    .EXT   (EXT)
  ) u_decode (
    .instr  (instr),
    .rb_low (src_b[3:0]),
    .op     (op_bus.producer)
  );

  // ---- issue ----
  wire issue_take = issue_valid && issue_ready;
  // privilege is judged at issue with the mode of that moment
  wire priv_now = (MMU_LEVEL >= 1) && (USER_ACCESS != 1)
                  && user_mode_flag;                       // see RL8
  assign issue_ready = state_reg == SLWU_IDLE;

  // ---- execution cycle ----
  wire in_exec   = state_reg == SLWU_EXEC;
  wire runnable  = in_exec && legal_reg && !priv_reg;
  // consumer space is sampled directly; far end is same-clock logic
  wire space_sel = link_space[link_reg];                    // see RL14
  // interrupts may break into a stalled blocking write only here
  wire irq_allowed = dyn_reg ? !atom_reg                    // see RL12
                             : (EXT == 1) && !atom_reg;     // see RL10
  wire blocked   = runnable && !nb_reg && !space_sel;       // see RL3
  wire abort_now = blocked && irq_pending && irq_allowed;
  wire finish_ok = runnable && (space_sel || nb_reg);       // see RL4
  // test form goes through the same checks but never strobes
  wire do_write  = finish_ok && space_sel && !test_reg;     // see RL6

  assign op_stall   = blocked && !abort_now;                // see RL3
  assign op_abort   = abort_now;
  assign op_done    = in_exec && !blocked;                  // see RL9
  assign carry_wr   = finish_ok && nb_reg;                  // see RL4
  assign carry_flag = !space_sel;                           // see RL4
  assign priv_fault = in_exec && legal_reg && priv_reg;     // see RL8
  assign illegal_op = in_exec && !legal_reg;                // see RL13
  assign exception_cause_field = cause_reg;

  // link data and control bit stand from flops for the whole attempt
  assign link_data = data_reg;                              // see RL1
  assign link_ctrl = ctrl_reg;                              // see RL5

  genvar gi;
  generate
    for (gi = 0; gi < LINKS; gi++) begin : g_link
      // see RL1, see RL2
      assign link_wr[gi] = do_write && (link_reg == 4'(gi));
    end
  endgenerate

  // atomic op keeps interrupts off while running and for the next one
  assign irq_block = inhibit_reg
                     || (state_reg != SLWU_IDLE && atom_reg); // see RL7

  // ---- next state ----
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SLWU_IDLE: begin
        if (issue_take)
          state_next = (AREA == 1) ? SLWU_SETTLE : SLWU_EXEC; // see RL9
      end
      SLWU_SETTLE: begin
        state_next = SLWU_EXEC;
      end
      SLWU_EXEC: begin
        if (!op_stall)
          state_next = SLWU_IDLE;
      end
    endcase
  end

  // set on atomic completion wins over a retire in the same cycle
  wire atomic_end = op_done && atom_reg && legal_reg && !priv_reg;
  assign inhibit_next = atomic_end ? 1'b1                   // see RL7
                      : retire_pulse ? 1'b0 : inhibit_reg;

  // stall cycles saturate so software sees a stuck link
  assign stall_cnt_next = (op_stall && stall_cnt_reg != slwu_pkg::STALL_MAX)
                          ? stall_cnt_reg + 16'h0001 : stall_cnt_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SLWU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // operand capture; test form has no source so the word is don't-care
  always_ff @(posedge clk) begin
    if (srst) begin
      data_reg  <= 32'h00000000;
      ctrl_reg  <= 1'b0;
      nb_reg    <= 1'b0;
      test_reg  <= 1'b0;
      atom_reg  <= 1'b0;
      dyn_reg   <= 1'b0;
      legal_reg <= 1'b0;
      priv_reg  <= 1'b0;
      link_reg  <= 4'h0;
    end else if (issue_take) begin
      data_reg  <= src_a;
      ctrl_reg  <= op_bus.control;                          // see RL5
      nb_reg    <= op_bus.nonblock;
      test_reg  <= op_bus.test;
      atom_reg  <= op_bus.atomic;
      dyn_reg   <= op_bus.dynamic;
      legal_reg <= op_bus.legal;
      priv_reg  <= priv_now;
      link_reg  <= op_bus.link;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inhibit_reg    <= 1'b0;
      cause_reg      <= 5'h00;
      carry_last_reg <= 1'b0;
      stall_cnt_reg  <= 16'h0000;
    end else begin
      inhibit_reg   <= inhibit_next;
      stall_cnt_reg <= stall_cnt_next;
      if (priv_fault)
        cause_reg <= slwu_pkg::EC_PRIV;                     // see RL8
      if (carry_wr)
        carry_last_reg <= carry_flag;
    end
  end

  // ---- software view ----
  wire [slwu_pkg::EVT_W-1:0] events;
  assign events[slwu_pkg::EV_WRITE]   = |link_wr;
  assign events[slwu_pkg::EV_NOSPACE] = carry_wr && carry_flag;
  assign events[slwu_pkg::EV_PRIV]    = priv_fault;
  assign events[slwu_pkg::EV_ABORT]   = op_abort;
  assign events[slwu_pkg::EV_ILLEGAL] = illegal_op;

  // state word: busy, stalled, inhibit, last carry, link, cause
  wire [31:0] state_word = {19'h00000, cause_reg, link_reg,
                            carry_last_reg, inhibit_reg, op_stall,
                            state_reg != SLWU_IDLE};

  slwu_regs u_regs (
    .clk         (clk),
    .srst        (srst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .events      (events),
    .state_word  (state_word),
    .stall_count (stall_cnt_reg),
    .irq         (irq)
  );
endmodule
`default_nettype wire

// ### bench/slwu_checker.sv
// concurrent checks on the ports of the stream link write unit
`timescale 1ns/1ns
`default_nettype none
module slwu_checker #(
  parameter int LINKS = 16
) (
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             issue_valid,
  input wire logic             issue_ready,
  input wire logic [31:0]      instr,
  input wire logic [31:0]      src_b,
  input wire logic             user_mode_flag,
  input wire logic             irq_pending,
  input wire logic             op_done,
  input wire logic             op_stall,
  input wire logic             op_abort,
  input wire logic             carry_wr,
  input wire logic             carry_flag,
  input wire logic             irq_block,
  input wire logic [LINKS-1:0] link_wr,
  input wire logic [LINKS-1:0] link_space
);
  wire logic       is_st = instr[31:26] == slwu_pkg::OPC_STATIC;
  wire logic       is_dy = instr[31:26] == slwu_pkg::OPC_DYNAMIC;
  wire logic       nb_w  = is_st ? instr[14] : is_dy && instr[9];
  wire logic       tst_w = is_st ? instr[12] : is_dy && instr[7];
  wire logic       atm_w = is_st ? instr[11] : is_dy && instr[6];
  wire logic [3:0] raw   = is_st ? instr[3:0] : src_b[3:0];
  wire logic [3:0] sel_next = (int'(raw) >= LINKS) ? 4'h0 : raw;
  logic [3:0]      sel_reg;
  logic            atm_reg;

  always_ff @(posedge clk) begin
    if (issue_valid && issue_ready) begin
      sel_reg <= sel_next;
      atm_reg <= atm_w;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_issue;
    issue_valid && issue_ready;
  endsequence
  sequence s_nb;
    s_issue ##0 nb_w;
  endsequence
  sequence s_tst;
    s_issue ##0 tst_w;
  endsequence
  sequence s_atm;
    s_issue ##0 (atm_w && !user_mode_flag && (is_st || is_dy));
  endsequence

  a_write_onehot: assert property ($onehot0(link_wr))
    else $error("more than one link strobed");
  a_write_link: assert property (|link_wr |->
    link_wr == (LINKS'(1) << sel_reg)) else $error("wrong link strobed");
  a_write_space: assert property (|link_wr |->
    (link_wr & ~link_space) == '0 && op_done) else $error("write w/o space");
  a_nb_nostall: assert property (s_nb |=> op_done && !op_stall)
    else $error("non-blocking op stalled");
  a_carry_value: assert property (carry_wr |->
    carry_flag == !link_space[sel_reg]) else $error("carry value wrong");
  a_test_nowrite: assert property (s_tst |=> (link_wr == '0) [*2])
    else $error("test form strobed a link");
  a_issue_latency: assert property (s_issue |=>
    !issue_ready && (op_done || op_stall || op_abort))
    else $error("no answer one cycle after issue");
  a_abort_cause: assert property (op_abort |->
    irq_pending && !atm_reg && !op_done && link_wr == '0)
    else $error("abort without cause");
  a_atomic_block: assert property (s_atm |=> irq_block)
    else $error("atomic op did not block interrupts");
endmodule
`default_nettype wire

// ### bench/slwu_consumer.sv
// stream consumer on the far side of the links
`timescale 1ns/1ns
`default_nettype none
module slwu_consumer #(
  parameter int LINKS = 16
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [31:0]       link_data,
  input wire logic              link_ctrl,
  input wire logic [LINKS-1:0]  link_wr,
  input wire logic [LINKS-1:0]  full_mask,
  output logic [LINKS-1:0]      link_space,
  output logic [31:0]           got_n,
  output logic [31:0]           got_data,
  output logic                  got_ctrl,
  output logic [31:0]           got_link
);
  // bench sets the mask to model a slow or stuck consumer
  assign link_space = ~full_mask;
  always @(posedge clk) begin
    if (srst)
      got_n <= 32'h0;
    else if (|(link_wr & link_space)) begin
      got_n <= got_n + 32'h1;
      got_data <= link_data;
      got_ctrl <= link_ctrl;
      for (int i = 0; i < LINKS; i++)
        if (link_wr[i]) got_link <= i;
    end
  end
endmodule
`default_nettype wire

// ### bench/slwu_top_test.sv
// self-checking bench for the stream link write unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module slwu_top_test;
  localparam int NL = 12;
  logic             clk, srst, issue_valid, user_mode_flag, irq_pending;
  logic             retire_pulse, reg_wr, reg_rd;
  logic [31:0]      instr, src_a, src_b, reg_wdata, v, r;
  logic [3:0]       reg_addr;
  logic [NL-1:0]    full_mask;
  logic [4:0]       mask, st_exp, ec;
  logic [31:0]      exp_q[$];
  wire logic        issue_ready, op_done, op_stall, op_abort, carry_wr;
  wire logic        carry_flag, priv_fault, illegal_op, irq_block;
  wire logic        link_ctrl, irq, got_ctrl;
  wire logic [4:0]  exception_cause_field;
  wire logic [31:0] link_data, reg_rdata, got_n, got_data, got_link;
  wire logic [NL-1:0] link_wr, link_space;
  int               fail_count, n_checks, cyc, stalls;
  integer           seed = 32'h5e5e9a55;

  slwu_top #(.LINKS(NL), .MMU_LEVEL(1)) i_slwu_top (.clk, .srst,
    .issue_valid, .issue_ready, .instr, .src_a, .src_b, .user_mode_flag,
    .irq_pending, .retire_pulse, .op_done, .op_stall, .op_abort, .carry_wr,
    .carry_flag, .priv_fault, .illegal_op, .exception_cause_field,
    .irq_block, .link_data, .link_ctrl, .link_wr, .link_space, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  slwu_consumer #(.LINKS(NL)) i_slwu_consumer (.clk, .srst, .link_data,
    .link_ctrl, .link_wr, .full_mask, .link_space, .got_n, .got_data,
    .got_ctrl, .got_link);

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end

  task automatic rd(input logic [3:0] ad);
    @(posedge clk); reg_rd <= 1; reg_addr <= ad;
    @(posedge clk); reg_rd <= 0;
    @(negedge clk); v = reg_rdata;
  endtask

  task automatic op(input bit st, n, c, t, a, ir, um, bad);
    int idx, k, i, n0;
    bit ok, sp, ab, wr;
    logic [31:0] ra, rb, ins, ed;
    ra = $random(seed); rb = $random(seed);
    idx = rb[3:0];
    ins = st ? {6'h1b, 10'h0, 1'b1, n, c, t, a, 7'h0, rb[3:0]}
             : {6'h13, 15'h0, 1'b1, n, c, t, a, 6'h0};
    if (bad) ins[31:26] = 6'h2a;
    k = idx >= NL ? 0 : idx;
    r = $random(seed);
    sp = !r[k];
    ok = !bad && !um;
    ab = ok && !n && !sp && ir && !a;
    wr = ok && !t && !ab && (!n || sp);
    n0 = got_n;
    if (wr) exp_q.push_back(ra);
    @(posedge clk); issue_valid <= 1; instr <= ins; src_a <= ra;
    src_b <= rb; user_mode_flag <= um; full_mask <= r[NL-1:0];
    @(posedge clk); issue_valid <= 0;
    i = 0;
    @(negedge clk);
    while (!(op_done || op_abort) && i < 20) begin
      i++;
      @(posedge clk);
      // irq raised mid-stall; atomic ops must ride it out
      if (i == 3) begin
        irq_pending <= ir;
        if (!ir || a) full_mask <= '0;
      end
      @(negedge clk);
    end
    stalls += i;
    `CHK("done", !ab, op_done)
    `CHK("abort", ab, op_abort)
    `CHK("stall", ok && !n && !sp, i > 0)
    `CHK("carry_wr", ok && n, carry_wr)
    if (ok && n) `CHK("carry", !sp, carry_flag)
    `CHK("priv", !bad && um, priv_fault)
    `CHK("illegal", bad, illegal_op)
    if (!bad && um) ec = slwu_pkg::EC_PRIV;
    st_exp = {bad, ab, !bad && um, ok && n && !sp, wr};
    @(posedge clk); irq_pending <= 0; full_mask <= '0; retire_pulse <= 1;
    @(negedge clk);
    `CHK("irq_block", a && ok, irq_block)
    `CHK("count", n0 + wr, got_n)
    if (wr) ed = exp_q.pop_front();
    if (wr) `CHK("data", ed, got_data)
    if (wr) `CHK("ctrl", c, got_ctrl)
    if (wr) `CHK("link", k, got_link)
    `CHK("cause", ec, exception_cause_field)
    `CHK("irq", |(st_exp & mask), irq)
    @(posedge clk); retire_pulse <= 0;
    @(negedge clk);
    `CHK("unblock", 1'b0, irq_block)
    rd(slwu_pkg::OFS_STATUS);
    `CHK("status", st_exp, v[4:0])
  endtask

  initial begin
    {issue_valid, user_mode_flag, irq_pending, retire_pulse} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, full_mask} = '0;
    {instr, src_a, src_b, ec} = '0;
    srst = 1;
    repeat (6) @(posedge clk);
    srst <= 0;
    rd(slwu_pkg::OFS_MASK);
    `CHK("mask reset", slwu_pkg::MASK_RST, v[4:0])
    rd(4'h2);
    `CHK("unmapped", 32'h0, v)
    mask = $random(seed);
    @(posedge clk); reg_wr <= 1; reg_addr <= slwu_pkg::OFS_MASK;
    reg_wdata <= {27'h0, mask};
    @(posedge clk); reg_wr <= 0;
    rd(slwu_pkg::OFS_MASK);
    `CHK("mask", mask, v[4:0])
    $display("test registers done");
    repeat (300) begin
      r = $random(seed);
      op(r[0], r[1], r[2], r[3], r[4], r[5], r[6] & r[10], r[9:7] == 3'h0);
    end
    rd(slwu_pkg::OFS_STALLS);
    `CHK("stalls", stalls, v)
    $display("test put ops done");
    wrap_up;
  end
endmodule

bind slwu_top slwu_checker #(.LINKS(LINKS)) i_slwu_checker (.clk, .srst,
  .issue_valid, .issue_ready, .instr, .src_b, .user_mode_flag, .irq_pending,
  .op_done, .op_stall, .op_abort, .carry_wr, .carry_flag, .irq_block,
  .link_wr, .link_space);
`default_nettype wire
